/* File: rtl/oscs_pkg.sv */
// Shared constants, encodings and helpers for the synthesizer control ends.
// Assumes both ends run from one system clock and one synchronous reset.
package oscs_pkg;
  localparam int          CLK_HZ       = 10_000_000;
  localparam int          ADDR_W       = 7;
  localparam int          DATA_W       = 8;
  localparam logic [4:0]  FRAME_BITS   = 5'h10;
  localparam logic [4:0]  ADDR_BITS    = 5'h07;
  localparam int          NUM_REGS     = 19;
  localparam int          NUM_OUT      = 5;
  localparam logic        RW_READ      = 1'b1;
  // Register indices
  localparam logic [6:0]  REG_STATUS   = 7'h00;
  localparam logic [6:0]  REG_CAL      = 7'h02;
  localparam logic [6:0]  REG_MODE     = 7'h03;
  localparam logic [6:0]  REG_BAND     = 7'h04;
  localparam logic [6:0]  REG_RDIV     = 7'h05;
  localparam logic [6:0]  REG_NDIV     = 7'h06;
  localparam logic [6:0]  REG_OUT_CFG0 = 7'h09;
  localparam logic [6:0]  REG_OUT_DLY0 = 7'h0a;
  localparam logic [6:0]  REG_LAST     = 7'h12;
  // Field positions
  localparam int          BIT_LOCK      = 2;
  localparam int          BIT_CAL       = 0;
  localparam int          BIT_WRITE_TRIGGERED_CALIBRATION   = 3;
  localparam int          BIT_RAO       = 2;
  localparam int          BIT_ALIGN_FB  = 7;
  localparam int          BIT_ALIGN_REF = 6;
  localparam int          BIT_OUT_ALIGN = 7;
  localparam int          BIT_OUT_MUTE  = 4;
  localparam int          RDIV_LSB      = 2;
  localparam int          BAND_LSB      = 4;
  // Reset values
  localparam logic [7:0]  RST_MODE     = 8'h08;
  // Timing
  localparam logic [9:0]  SILENT_P_CYCLES = 10'h012;
  localparam int          SYNC_MIN_MS     = 1;
  localparam int          MS_PER_S        = 1000;

  typedef enum logic [1:0] {
    CAL_IDLE   = 2'h0,
    CAL_RUN    = 2'h1,
    CAL_SETTLE = 2'h3,
    CAL_LOCKED = 2'h2
  } oscs_cal_t;

  typedef enum logic [1:0] {
    HS_IDLE  = 2'h0,
    HS_SHIFT = 2'h1,
    HS_END   = 2'h3
  } oscs_hser_t;

  // Output divide code to ratio
  function automatic logic [9:0] out_div_ratio(input logic [3:0] code);
    logic [9:0] r;
    r = 10'h001;
    case (code)
      4'h0: r = 10'h001;
      4'h1: r = 10'h002;
      4'h2: r = 10'h004;
      4'h3: r = 10'h008;
      4'h4: r = 10'h00c;
      4'h5: r = 10'h010;
      4'h6: r = 10'h018;
      4'h7: r = 10'h020;
      4'h8: r = 10'h030;
      4'h9: r = 10'h040;
      4'ha: r = 10'h060;
      4'hb: r = 10'h080;
      4'hc: r = 10'h0c0;
      4'hd: r = 10'h100;
      4'he: r = 10'h180;
      default: r = 10'h200;
    endcase
    return r;
  endfunction

  // Band divide code to value
  function automatic logic [9:0] band_div(input logic [3:0] code);
    logic [9:0] b;
    b = {code, 6'h00};
    if (code == 4'ha) b = 10'h100;
    if (code == 4'hb) b = 10'h180;
    return b;
  endfunction

  // Delay setting for reference-aligned mode
  function automatic int delay_setting(input int dxi, input int n, input int m0);
    int prod;
    prod = n * m0;
    return dxi + ((int'(SILENT_P_CYCLES) + prod - 1) / prod) * prod - int'(SILENT_P_CYCLES);
  endfunction

  // Alignment bits for output-0 delay register
  function automatic logic [7:0] align_bits(input int r);
    logic [7:0] v;
    v = 8'h00;
    v[BIT_ALIGN_FB] = 1'b1;
    v[BIT_ALIGN_REF] = (r >= 2);
    return v;
  endfunction

  // Alignment pulse width in reference periods
  function automatic int sync_width(input int ref_hz);
    int per;
    per = ref_hz / MS_PER_S * SYNC_MIN_MS;
    return 2 * ((per + 1) / 2) + 1;
  endfunction
endpackage

/* File: rtl/oscs_if.sv */
// Link between host controller and synthesizer control logic.
// Assumes all signals are synchronous to the shared system clock.
`timescale 1ns/10ps
interface oscs_if;
  logic cs_n;
  logic sck;
  logic sdi;
  logic sdo;
  logic stat;
  logic sync;
  logic ref_tick;

  modport dev  (input cs_n, sck, sdi, sync, ref_tick, output sdo, stat);
  modport host (output cs_n, sck, sdi, sync, ref_tick, input sdo, stat);
endinterface

/* File: rtl/oscs_device.sv */
// Synthesizer control end: serial registers, calibration, lock, output restart.
// Assumes link inputs are synchronous to CLK_SYS and host frames are 16 bits.
`timescale 1ns/10ps
module oscs_device #(
  parameter logic [15:0] CAL_STEP   = 16'h0001,
  parameter logic [7:0]  LOCK_EDGES = 8'h04,
  parameter logic [3:0]  PRESC_DIV  = 4'h2
) (
  input  wire logic       CLK_SYS,  // System clock
  input  wire logic       SYS_RST,  // Synchronous reset, high
  oscs_if.dev             LINK,     // Serial port, sync, status
  output logic [4:0]      OUT_CLK,  // Output clock levels
  output logic            CAL_BUSY  // Calibration running
);

  typedef struct packed {
    logic [18:0][7:0]   regs;
    logic [15:0]        shin;
    logic [7:0]         shout;
    logic [4:0]         bits;
    logic               sck_q;
    logic               cs_q;
    logic               sync_q;
    oscs_pkg::oscs_cal_t cal;
    logic [15:0]        cal_cnt;
    logic               lock;
    logic               busy;
    logic [3:0]         p_cnt;
    logic [5:0]         r_cnt;
    logic [7:0]         n_cnt;
    logic [4:0][9:0]    ocnt;
    logic [4:0][9:0]    osil;
    logic [4:0]         run;
    logic [4:0]         oclk;
    logic               pend;
    logic               sdo;
    logic               stat;
  } oscs_dev_state_t;

  oscs_dev_state_t s_reg;
  oscs_dev_state_t s_next;

  // Register read view
  function automatic logic [7:0] read_byte(input oscs_dev_state_t st, input logic [6:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == oscs_pkg::REG_STATUS) begin
      v[oscs_pkg::BIT_LOCK] = st.lock;
    end else if (a <= oscs_pkg::REG_LAST) begin
      v = st.regs[a];
    end
    return v;
  endfunction

  always_comb begin
    logic       sck_rise;
    logic       sck_fall;
    logic       cs_rise;
    logic       reference_aligned_output_mode;
    logic       p_tick;
    logic       r_edge;
    logic       fb_src;
    logic       fb_edge;
    logic       retime;
    logic       cal_req;
    logic [6:0] waddr;
    logic [7:0] wdata;
    logic [5:0] rdiv;
    logic [7:0] ndiv;
    logic [7:0] cfg;
    logic [9:0] ratio;
    logic [9:0] ratio0;
    logic       aligned;
    sck_rise = 1'b0;
    sck_fall = 1'b0;
    cs_rise  = 1'b0;
    reference_aligned_output_mode      = 1'b0;
    p_tick   = 1'b0;
    r_edge   = 1'b0;
    fb_src   = 1'b0;
    fb_edge  = 1'b0;
    retime   = 1'b0;
    cal_req  = 1'b0;
    waddr    = 7'h00;
    wdata    = 8'h00;
    rdiv     = 6'h00;
    ndiv     = 8'h00;
    cfg      = 8'h00;
    ratio    = 10'h000;
    ratio0   = 10'h000;
    aligned  = 1'b0;
    s_next   = s_reg;

    sck_rise = LINK.sck & ~s_reg.sck_q;
    sck_fall = ~LINK.sck & s_reg.sck_q;
    cs_rise  = LINK.cs_n & ~s_reg.cs_q;
    reference_aligned_output_mode      = s_reg.regs[oscs_pkg::REG_MODE][oscs_pkg::BIT_RAO];
    s_next.sck_q  = LINK.sck;
    s_next.cs_q   = LINK.cs_n;
    s_next.sync_q = LINK.sync;

    // Serial shift in, read data out
    if (LINK.cs_n) begin
      s_next.bits = 5'h00;
    end else if (sck_rise && s_reg.bits != oscs_pkg::FRAME_BITS) begin
      s_next.shin = {s_reg.shin[14:0], LINK.sdi};
      s_next.bits = 5'(s_reg.bits + 5'h01);
      if (s_reg.bits == oscs_pkg::ADDR_BITS) begin
        s_next.shout = read_byte(s_reg, s_reg.shin[6:0]);
      end
    end else if (sck_fall && s_reg.bits > oscs_pkg::ADDR_BITS) begin
      s_next.sdo   = s_reg.shout[7];
      s_next.shout = {s_reg.shout[6:0], 1'b0};
    end

    // Calibration sequence
    unique case (s_reg.cal)
      oscs_pkg::CAL_IDLE: begin
      end
      oscs_pkg::CAL_RUN: begin
        if (s_reg.cal_cnt == 16'h0000) begin
          s_next.cal = oscs_pkg::CAL_SETTLE;
          s_next.regs[oscs_pkg::REG_CAL][oscs_pkg::BIT_CAL] = 1'b0;
          retime = 1'b1;
        end else begin
          s_next.cal_cnt = 16'(s_reg.cal_cnt - 16'h0001);
        end
      end
      oscs_pkg::CAL_SETTLE: begin
      end
      oscs_pkg::CAL_LOCKED: begin
      end
    endcase

    // Prescaler enable
    if (s_reg.p_cnt >= 4'(PRESC_DIV - 4'h1)) begin
      s_next.p_cnt = 4'h0;
      p_tick = 1'b1;
    end else begin
      s_next.p_cnt = 4'(s_reg.p_cnt + 4'h1);
    end

    // Reference divider
    rdiv = s_reg.regs[oscs_pkg::REG_RDIV][7:oscs_pkg::RDIV_LSB];
    if (rdiv == 6'h00) rdiv = 6'h01;
    if (LINK.ref_tick) begin
      if (s_reg.r_cnt >= 6'(rdiv - 6'h01)) begin
        s_next.r_cnt = 6'h00;
        r_edge = 1'b1;
      end else begin
        s_next.r_cnt = 6'(s_reg.r_cnt + 6'h01);
      end
    end
    // align bits read from delay register
    if (LINK.sync && !s_reg.sync_q &&
        (!reference_aligned_output_mode || s_reg.regs[oscs_pkg::REG_OUT_DLY0][oscs_pkg::BIT_ALIGN_REF])) begin
      s_next.r_cnt = 6'h00;
    end

    // Loop settling counted in comparison edges
    if (s_reg.cal == oscs_pkg::CAL_SETTLE && r_edge) begin
      if (s_reg.cal_cnt >= 16'(LOCK_EDGES - 8'h01)) begin
        s_next.cal  = oscs_pkg::CAL_LOCKED;
        s_next.lock = 1'b1;
      end else begin
        s_next.cal_cnt = 16'(s_reg.cal_cnt + 16'h0001);
      end
    end

    // Feedback divider
    ratio0 = oscs_pkg::out_div_ratio(s_reg.regs[oscs_pkg::REG_OUT_CFG0][3:0]);
    ndiv = s_reg.regs[oscs_pkg::REG_NDIV];
    if (ndiv == 8'h00) ndiv = 8'h01;
    fb_src = reference_aligned_output_mode ? (p_tick && s_reg.run[0] && s_reg.ocnt[0] == 10'(ratio0 - 10'h001))
                 : p_tick;
    if (fb_src) begin
      if (s_reg.n_cnt >= 8'(ndiv - 8'h01)) begin
        s_next.n_cnt = 8'h00;
        fb_edge = 1'b1;
      end else begin
        s_next.n_cnt = 8'(s_reg.n_cnt + 8'h01);
      end
    end

    if (s_reg.pend && fb_edge) begin
      s_next.pend = 1'b0;
      retime = 1'b1;
    end
    if (!LINK.sync && s_reg.sync_q) begin
      if (reference_aligned_output_mode && s_reg.regs[oscs_pkg::REG_OUT_DLY0][oscs_pkg::BIT_ALIGN_FB]) begin
        s_next.pend = 1'b1;
      end else begin
        retime = 1'b1;
      end
    end
    if (retime) s_next.n_cnt = 8'h00;

    if (cs_rise && s_reg.bits == oscs_pkg::FRAME_BITS && s_reg.shin[8] != oscs_pkg::RW_READ) begin
      waddr = s_reg.shin[15:9];
      wdata = s_reg.shin[7:0];
      if (waddr != oscs_pkg::REG_STATUS && waddr <= oscs_pkg::REG_LAST) begin
        s_next.regs[waddr] = wdata;
        if (waddr == oscs_pkg::REG_CAL && wdata[oscs_pkg::BIT_CAL]) cal_req = 1'b1;
        if (waddr != oscs_pkg::REG_CAL &&
            s_next.regs[oscs_pkg::REG_MODE][oscs_pkg::BIT_WRITE_TRIGGERED_CALIBRATION]) cal_req = 1'b1;
      end
    end
    if (cal_req) begin
      s_next.cal  = oscs_pkg::CAL_RUN;
      s_next.lock = 1'b0;
      s_next.cal_cnt = 16'(oscs_pkg::band_div(
        s_next.regs[oscs_pkg::REG_BAND][7:oscs_pkg::BAND_LSB]) * CAL_STEP);
    end

    // Output dividers
    for (int i = 0; i < oscs_pkg::NUM_OUT; i++) begin
      cfg = s_reg.regs[oscs_pkg::REG_OUT_CFG0 + 7'(2 * i)];
      ratio = oscs_pkg::out_div_ratio(cfg[3:0]);
      aligned = (reference_aligned_output_mode && i == 0) ? 1'b1 : cfg[oscs_pkg::BIT_OUT_ALIGN];
      if (retime && aligned) begin
        s_next.run[i]  = 1'b0;
        s_next.ocnt[i] = 10'h000;
        s_next.osil[i] = (reference_aligned_output_mode && i == 0) ? oscs_pkg::SILENT_P_CYCLES :
          10'(oscs_pkg::SILENT_P_CYCLES + {2'b00, s_reg.regs[oscs_pkg::REG_OUT_DLY0 + 7'(2 * i)]});
      end else if (p_tick) begin
        if (!s_reg.run[i]) begin
          if (s_reg.osil[i] == 10'h000) begin
            s_next.run[i] = 1'b1;
          end else begin
            s_next.osil[i] = 10'(s_reg.osil[i] - 10'h001);
          end
        end else if (s_reg.ocnt[i] >= 10'(ratio - 10'h001)) begin
          s_next.ocnt[i] = 10'h000;
        end else begin
          s_next.ocnt[i] = 10'(s_reg.ocnt[i] + 10'h001);
        end
      end
      // output 0 restarts at feedback edge
      if (reference_aligned_output_mode && i == 0 && fb_edge && s_reg.run[0]) s_next.ocnt[0] = 10'h000;
      s_next.oclk[i] = s_next.run[i] &&
        (ratio == 10'h001 || s_next.ocnt[i] < {1'b0, ratio[9:1]});
      if (cfg[oscs_pkg::BIT_OUT_MUTE] && s_next.cal == oscs_pkg::CAL_RUN) s_next.oclk[i] = 1'b0;
    end

    s_next.busy = (s_next.cal == oscs_pkg::CAL_RUN);
    s_next.stat = ~s_next.lock;
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      s_reg <= '0;
      s_reg.regs[oscs_pkg::REG_MODE] <= oscs_pkg::RST_MODE;
      s_reg.stat <= 1'b1;
      s_reg.sck_q <= 1'b0;
      s_reg.cs_q <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign OUT_CLK   = s_reg.oclk;
  assign CAL_BUSY  = s_reg.busy;
  assign LINK.sdo  = s_reg.sdo;
  assign LINK.stat = s_reg.stat;
endmodule

/* File: rtl/oscs_host.sv */
// Host end: serial register master, calibrate command, reference and pulse.
// Assumes the device samples on rising serial clock and commits on select rise.
`timescale 1ns/10ps
module oscs_host #(
  parameter logic [7:0]  SCK_HALF         = 8'h04,
  parameter logic [7:0]  REF_DIV          = 8'h0a,
  parameter logic [19:0] SYNC_REF_PERIODS =
    20'(oscs_pkg::sync_width(oscs_pkg::CLK_HZ / 10))
) (
  input  wire logic       CLK_SYS,    // System clock
  input  wire logic       SYS_RST,    // Synchronous reset, high
  oscs_if.host            LINK,       // Serial port, sync, status
  input  wire logic       CMD_VALID,  // Register access request
  input  wire logic       CMD_WRITE,  // 1 write, 0 read
  input  wire logic [6:0] CMD_ADDR,   // Register index
  input  wire logic [7:0] CMD_DATA,   // Write data
  output logic            CMD_READY,  // Idle, request taken
  input  wire logic       CAL_START,  // Issue calibrate command
  output logic            RSP_VALID,  // Access done pulse
  output logic [7:0]      RSP_DATA,   // Read data
  input  wire logic       SYNC_START, // Start alignment pulse
  output logic            SYNC_BUSY,  // Pulse pending or high
  output logic            LOCKED      // Device reports lock
);

  typedef struct packed {
    oscs_pkg::oscs_hser_t st;
    logic [7:0]  cnt;
    logic [15:0] sh;
    logic [7:0]  rd;
    logic [4:0]  bits;
    logic        sck;
    logic        cs_n;
    logic        sdi;
    logic        rd_op;
    logic        ready;
    logic        rsp_valid;
    logic [7:0]  rsp_data;
    logic [7:0]  ref_cnt;
    logic        ref_tick;
    logic        sync;
    logic        arm;
    logic        sbusy;
    logic [19:0] sync_cnt;
    logic        locked;
  } oscs_host_state_t;

  oscs_host_state_t s_reg;
  oscs_host_state_t s_next;

  always_comb begin
    logic [15:0] frame;
    frame = 16'h0000;
    s_next = s_reg;
    s_next.rsp_valid = 1'b0;
    s_next.locked = ~LINK.stat;

    unique case (s_reg.st)
      oscs_pkg::HS_IDLE: begin
        if (s_reg.ready && (CAL_START || CMD_VALID)) begin
          frame = CAL_START ? {oscs_pkg::REG_CAL, ~oscs_pkg::RW_READ, 8'h01}
                            : {CMD_ADDR, ~CMD_WRITE, CMD_DATA};
          s_next.sh    = frame;
          s_next.sdi   = frame[15];
          s_next.rd_op = frame[8];
          s_next.cs_n  = 1'b0;
          s_next.sck   = 1'b0;
          s_next.bits  = 5'h00;
          s_next.cnt   = 8'h00;
          s_next.ready = 1'b0;
          s_next.st    = oscs_pkg::HS_SHIFT;
        end
      end
      oscs_pkg::HS_SHIFT: begin
        if (s_reg.cnt >= 8'(SCK_HALF - 8'h01)) begin
          s_next.cnt = 8'h00;
          if (!s_reg.sck) begin
            s_next.sck  = 1'b1;
            s_next.rd   = {s_reg.rd[6:0], LINK.sdo};
            s_next.bits = 5'(s_reg.bits + 5'h01);
          end else begin
            s_next.sck = 1'b0;
            if (s_reg.bits == oscs_pkg::FRAME_BITS) begin
              s_next.cs_n = 1'b1;
              s_next.st   = oscs_pkg::HS_END;
            end else begin
              s_next.sh  = {s_reg.sh[14:0], 1'b0};
              s_next.sdi = s_reg.sh[14];
            end
          end
        end else begin
          s_next.cnt = 8'(s_reg.cnt + 8'h01);
        end
      end
      oscs_pkg::HS_END: begin
        if (s_reg.cnt >= 8'(SCK_HALF - 8'h01)) begin
          s_next.st        = oscs_pkg::HS_IDLE;
          s_next.ready     = 1'b1;
          s_next.rsp_valid = 1'b1;
          s_next.rsp_data  = s_reg.rd_op ? s_reg.rd : 8'h00;
        end else begin
          s_next.cnt = 8'(s_reg.cnt + 8'h01);
        end
      end
      default: begin
        s_next.st = oscs_pkg::HS_IDLE;
      end
    endcase

    // Reference enable
    s_next.ref_tick = 1'b0;
    if (s_reg.ref_cnt >= 8'(REF_DIV - 8'h01)) begin
      s_next.ref_cnt  = 8'h00;
      s_next.ref_tick = 1'b1;
    end else begin
      s_next.ref_cnt = 8'(s_reg.ref_cnt + 8'h01);
    end

    if (SYNC_START && !s_reg.sbusy) begin
      s_next.arm   = 1'b1;
      s_next.sbusy = 1'b1;
    end
    if (s_next.ref_tick) begin
      if (s_reg.arm) begin
        s_next.arm      = 1'b0;
        s_next.sync     = 1'b1;
        s_next.sync_cnt = 20'h0_0000;
      end else if (s_reg.sync) begin
        if (s_reg.sync_cnt >= 20'(SYNC_REF_PERIODS - 20'h0_0001)) begin
          s_next.sync  = 1'b0;
          s_next.sbusy = 1'b0;
        end else begin
          s_next.sync_cnt = 20'(s_reg.sync_cnt + 20'h0_0001);
        end
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      s_reg <= '0;
      s_reg.cs_n <= 1'b1;
      s_reg.ready <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign LINK.cs_n     = s_reg.cs_n;
  assign LINK.sck      = s_reg.sck;
  assign LINK.sdi      = s_reg.sdi;
  assign LINK.sync     = s_reg.sync;
  assign LINK.ref_tick = s_reg.ref_tick;
  assign CMD_READY     = s_reg.ready;
  assign RSP_VALID     = s_reg.rsp_valid;
  assign RSP_DATA      = s_reg.rsp_data;
  assign SYNC_BUSY     = s_reg.sbusy;
  assign LOCKED        = s_reg.locked;
endmodule

/* File: verif/oscs_assertions.sv */
// Checker on the link signals between host and device ends.
// Assumes host defaults of 4 cycles per serial half period, tick every 10.
`timescale 1ns/10ps
module oscs_assertions #(
  parameter logic [19:0] SYNC_REF_PERIODS = 20'h0_0005
) (
  input wire logic CLK_SYS,  // System clock
  input wire logic SYS_RST,  // Synchronous reset
  input wire logic cs_n,     // Select, low active
  input wire logic sck,      // Serial clock
  input wire logic sdi,      // Host data
  input wire logic sdo,      // Device data
  input wire logic stat,     // Condition pin
  input wire logic sync,     // Alignment pulse
  input wire logic ref_tick  // Reference enable
);
  logic [4:0]  rise_cnt_reg;
  logic [19:0] tick_cnt_reg;
  logic        sck_d_reg;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);

  // Serial clock rises per frame, ticks per pulse
  always_ff @(posedge CLK_SYS) begin
    sck_d_reg <= sck;
    if (SYS_RST || cs_n) rise_cnt_reg <= 5'h00;
    else if (sck && !sck_d_reg) rise_cnt_reg <= rise_cnt_reg + 5'h01;
    if (SYS_RST || !sync) tick_cnt_reg <= 20'h0_0000;
    else if (ref_tick) tick_cnt_reg <= tick_cnt_reg + 20'h0_0001;
  end

  sequence s_sck_high;
    sck [*4];
  endsequence
  sequence s_tick_gap;
    !ref_tick [*8] ##1 !ref_tick;
  endsequence

  AST_SCK_IDLE: assert property (cs_n |-> !sck)
    else $error("serial clock moves outside a frame");
  AST_FRAME_BITS: assert property ($rose(cs_n) |-> rise_cnt_reg == 5'h10)
    else $error("frame not sixteen bits");
  AST_SCK_HALF: assert property ($rose(sck) |-> s_sck_high ##1 !sck)
    else $error("serial clock half period wrong");
  AST_SDI_HOLD: assert property (sck |-> $stable(sdi))
    else $error("host data moved while clock high");
  AST_STAT_RISE: assert property ($rose(stat) |-> cs_n && $past(cs_n))
    else $error("lock lost without a committed write");
  AST_TICK_GAP: assert property (ref_tick |=> s_tick_gap ##1 ref_tick)
    else $error("reference tick spacing wrong");
  AST_SYNC_TICK: assert property ($rose(sync) |-> $past(ref_tick) || ref_tick)
    else $error("pulse not aligned to reference");
  AST_SYNC_WIDTH: assert property ($fell(sync) |->
    tick_cnt_reg >= SYNC_REF_PERIODS - 20'h0_0001 &&
    tick_cnt_reg <= SYNC_REF_PERIODS + 20'h0_0001)
    else $error("pulse width wrong");
endmodule

/* File: verif/tb_top.sv */
// Bench joining host and device ends across the link.
// Assumes host defaults except a short alignment pulse.
`timescale 1ns/10ps
module tb_top;
  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] wr;
    logic [7:0] rd;
  } oscs_row_t;

  logic       clk        = 1'b0;
  logic       rst        = 1'b1;
  logic       cmd_valid  = 1'b0;
  logic       cmd_write  = 1'b0;
  logic [6:0] cmd_addr   = 7'h00;
  logic [7:0] cmd_data   = 8'h00;
  logic       cal_start  = 1'b0;
  logic       sync_start = 1'b0;
  logic       cmd_ready;
  logic       rsp_valid;
  logic [7:0] rsp_data;
  logic       sync_busy;
  logic       locked;
  logic [4:0] out_clk;
  logic       cal_busy;
  logic [7:0] rd;
  int         n;
  int         k;
  int         m;
  int         num_errors = 0;
  int         checked    = 0;
  oscs_row_t  rows [8]   = '{
    '{oscs_pkg::REG_MODE, 8'h74, 8'h74}, '{oscs_pkg::REG_BAND, 8'ha3, 8'ha3},
    '{oscs_pkg::REG_RDIV, 8'h08, 8'h08}, '{oscs_pkg::REG_NDIV, 8'h05, 8'h05},
    '{oscs_pkg::REG_OUT_CFG0, 8'h13, 8'h13}, '{oscs_pkg::REG_OUT_DLY0, 8'hc0, 8'hc0},
    '{7'h0d, 8'h92, 8'h92}, '{7'h13, 8'h55, 8'h00}};

  oscs_if link ();
  oscs_device oscs_device_i (.CLK_SYS(clk), .SYS_RST(rst), .LINK(link),
    .OUT_CLK(out_clk), .CAL_BUSY(cal_busy));
  oscs_host #(.SYNC_REF_PERIODS(20'h0_0005)) oscs_host_i (.CLK_SYS(clk), .SYS_RST(rst),
    .LINK(link), .CMD_VALID(cmd_valid), .CMD_WRITE(cmd_write), .CMD_ADDR(cmd_addr),
    .CMD_DATA(cmd_data), .CMD_READY(cmd_ready), .CAL_START(cal_start),
    .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data), .SYNC_START(sync_start),
    .SYNC_BUSY(sync_busy), .LOCKED(locked));
  oscs_assertions #(.SYNC_REF_PERIODS(20'h0_0005)) oscs_assertions_i (.CLK_SYS(clk),
    .SYS_RST(rst), .cs_n(link.cs_n), .sck(link.sck), .sdi(link.sdi), .sdo(link.sdo),
    .stat(link.stat), .sync(link.sync), .ref_tick(link.ref_tick));

  initial begin
    forever #50 clk = ~clk;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    if (num_errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic wait_for(input int sel, input logic val, input int lim);
    logic s;
    for (int i = 0; i <= lim; i++) begin
      @(negedge clk);
      case (sel)
        0: s = rsp_valid;
        1: s = cal_busy;
        2: s = locked;
        3: s = sync_busy;
        4: s = out_clk[0];
        default: s = out_clk[2];
      endcase
      if (s === val) return;
    end
    num_errors++;
    $display("wrong value at %0t: wait ran out", $time);
    wrap_up();
  endtask

  // One access or calibrate command, answer taken with its pulse
  task automatic access(input logic c, input logic w, input logic [6:0] a,
                        input logic [7:0] d, output logic [7:0] q);
    @(negedge clk);
    cal_start = c;
    cmd_valid = !c;
    cmd_write = w;
    cmd_addr = a;
    cmd_data = d;
    @(negedge clk);
    cal_start = 1'b0;
    cmd_valid = 1'b0;
    wait_for(0, 1'b1, 400);
    q = rsp_data;
  endtask

  initial begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    chk({7'h00, link.stat}, 8'h01);
    chk({7'h00, locked}, 8'h00);
    access(1'b0, 1'b0, oscs_pkg::REG_MODE, 8'h00, rd);
    chk(rd, oscs_pkg::RST_MODE);
    for (n = 0; n < 8; n++) begin
      access(1'b0, 1'b1, rows[n].addr, rows[n].wr, rd);
      access(1'b0, 1'b0, rows[n].addr, 8'h00, rd);
      chk(rd, rows[n].rd);
    end
    repeat (400) @(negedge clk);
    // Explicit calibrate, then silence and lock
    access(1'b1, 1'b1, oscs_pkg::REG_CAL, 8'h01, rd);
    wait_for(1, 1'b1, 10);
    chk({6'h00, link.stat, locked}, 8'h02);
    for (n = 0; n < 400 && cal_busy === 1'b1; n++) @(negedge clk);
    chk({7'h00, n >= 250 && n <= 257}, 8'h01);
    for (n = 0; n < 2000 && out_clk[0] !== 1'b1; n++) @(negedge clk);
    chk({7'h00, n >= 2 * oscs_pkg::SILENT_P_CYCLES && n <= 40}, 8'h01);
    wait_for(2, 1'b1, 1000);
    chk({7'h00, link.stat}, 8'h00);
    access(1'b0, 1'b0, oscs_pkg::REG_CAL, 8'h00, rd);
    chk(rd, 8'h00);
    access(1'b0, 1'b0, oscs_pkg::REG_STATUS, 8'h00, rd);
    chk(rd & 8'h04, 8'h04);
    access(1'b0, 1'b1, oscs_pkg::REG_NDIV, 8'h05, rd);
    repeat (20) @(negedge clk);
    chk({6'h00, cal_busy, locked}, 8'h01);
    sync_start = 1'b1;
    @(negedge clk);
    sync_start = 1'b0;
    wait_for(3, 1'b0, 300);
    chk({7'h00, link.sync}, 8'h00);
    k = 0;
    m = 0;
    for (n = 0; n < 300; n++) begin
      @(negedge clk);
      k = out_clk[0] ? 0 : k + 1;
      if (k > m) m = k;
    end
    chk({7'h00, m >= 2 * oscs_pkg::SILENT_P_CYCLES}, 8'h01);
    wait_for(4, 1'b1, 50);
    chk({7'h00, out_clk[0]}, 8'h01);
    wait_for(5, 1'b0, 50);
    wait_for(5, 1'b1, 50);
    for (n = 0; n < 20 && out_clk[2] === 1'b1; n++) @(negedge clk);
    chk(8'(n), 8'h04);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    chk({6'h00, cal_busy, link.stat}, 8'h01);
    access(1'b0, 1'b0, oscs_pkg::REG_MODE, 8'h00, rd);
    chk(rd, oscs_pkg::RST_MODE);
    chk(8'(oscs_pkg::delay_setting(2, 5, 8)), 8'h18);
    chk(8'(oscs_pkg::delay_setting(0, 5, 8)), 8'h16);
    chk(oscs_pkg::align_bits(2), 8'hc0);
    chk(oscs_pkg::align_bits(1), 8'h80);
    chk({7'h00, oscs_pkg::sync_width(32'h05f5_e100) == 32'h0001_86a1}, 8'h01);
    wrap_up();
  end
endmodule
